//--- hw/dfpsm_fan_meter.sv
// One fan speed meter: pulse synchroniser, edge counter and gated speed register
`timescale 1ns/1ps
`default_nettype none
`include "dfpsm_params.svh"

module dfpsm_fan_meter
  import dfpsm_pkg::*;
(
  input  wire logic       sys_clk,    // System clock
  input  wire logic       rstn,       // Synchronous reset, active low
  input  wire logic       pulseIn,    // Commutation pulse sense
  input  wire logic [1:0] pprCode,    // Pulses per revolution code
  input  wire logic       gateEnd,    // Window end pulse
  output var  logic [8:0] speedCount, // Speed in 25 RPM counts
  output var  logic       overflow    // Speed above the maximum
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  dfpsm_meter_state_t cur;  // Registered state
  dfpsm_meter_state_t nxt;  // Next state

  localparam dfpsm_meter_state_t METER_RESET = '{
    sync1: 1'b0, sync2: 1'b0, prev: 1'b0, pulseCnt: 16'h0000,
    count: 9'h000, ovf: 1'b0
  };

  logic        rise;     // Qualified rising edge
  logic [15:0] scaled;   // Window pulses divided by pulses per rev

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Window of 2.4 s makes pulses per rev equal to counts of 25 RPM
  always_comb begin
    nxt    = cur;
    // Only the second stage reads the first
    nxt.sync1 = pulseIn;  // R19
    nxt.sync2 = cur.sync1;
    nxt.prev  = cur.sync2;
    rise      = cur.sync2 & ~cur.prev;  // R19
    // Code 0..3 means 1, 2, 4 or 8 pulses, so a plain shift divides
    scaled    = cur.pulseCnt >> pprCode;  // R13
    if (gateEnd) begin
      // Edge on the window end starts the next window
      nxt.pulseCnt = rise ? 16'h0001 : 16'h0000;
      if (scaled > {7'h00, `DFPSM_SPEED_MAX}) begin
        // Above 12775 RPM the reading pins at full scale
        nxt.count = `DFPSM_SPEED_MAX;  // R14
        nxt.ovf   = 1'b1;  // R16
      end else begin
        nxt.count = scaled[8:0];  // R14
        // Whole window below the maximum releases the flag
        nxt.ovf   = 1'b0;  // R17
      end
    end else if (rise && (cur.pulseCnt != 16'hffff)) begin
      // Saturate rather than wrap on a runaway input
      nxt.pulseCnt = cur.pulseCnt + 16'h0001;  // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Single state register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cur <= METER_RESET;
    end else begin
      cur <= nxt;
    end
  end

  assign speedCount = cur.count;
  assign overflow   = cur.ovf;

endmodule : dfpsm_fan_meter
`default_nettype wire

//--- hw/dfpsm_params.svh
// Constants for the dual fan PWM drive and speed monitor: timing, thresholds and codes
`ifndef DFPSM_PARAMS_SVH
`define DFPSM_PARAMS_SVH

// System clock rate in MHz (10 ns period)
`define DFPSM_CLK_MHZ          100

// Forced full-on start-up time, in milliseconds, and its cycle count
`define DFPSM_STARTUP_MS       1000
`define DFPSM_STARTUP_CYCLES   (`DFPSM_STARTUP_MS * `DFPSM_CLK_MHZ * 1000)

// Speed gate window and overflow release time, in milliseconds, and its cycle count
`define DFPSM_GATE_MS          2400
`define DFPSM_GATE_CYCLES      (`DFPSM_GATE_MS * `DFPSM_CLK_MHZ * 1000)

// PWM period (about 30 Hz) in microseconds, split into equal duty steps
`define DFPSM_PWM_PERIOD_US    33333
`define DFPSM_PWM_STEPS        256
`define DFPSM_PWM_STEP_CYCLES  ((`DFPSM_PWM_PERIOD_US * `DFPSM_CLK_MHZ) / `DFPSM_PWM_STEPS)
`define DFPSM_PWM_LAST_STEP    8'hff

// Analog input range in millivolts: 1620 mV and 2600 mV
`define DFPSM_VIN_LOW_MV       12'h654
`define DFPSM_VIN_HIGH_MV      12'ha28
`define DFPSM_VIN_SPAN_MV      32'h3d4

// Duty in PWM steps: 30 % is 77 of 256, 100 % is all 256
`define DFPSM_DUTY_MIN_STEPS   9'h04d
`define DFPSM_DUTY_FULL_STEPS  9'h100
`define DFPSM_DUTY_RISE_STEPS  32'hb3

// Duty code scale in parts of 300: 90 base, 14 per code
`define DFPSM_DUTY_BASE_PARTS  32'h5a
`define DFPSM_DUTY_CODE_PARTS  32'he
`define DFPSM_DUTY_ALL_PARTS   32'h12c

// Duty code used for an open analog input, and the duty register reset value
`define DFPSM_DUTY_OPEN_CODE   4'h2
`define DFPSM_DUTY_RESET       4'h2

// Largest speed count: 511 counts of 25 RPM is 12775 RPM
`define DFPSM_SPEED_MAX        9'h1ff

`endif

//--- hw/dfpsm_pkg.sv
// Types shared by the dual fan PWM drive and speed monitor
package dfpsm_pkg;

  // Drive sequencer states
  typedef enum logic [1:0] {
    DFPSM_SHUT,
    DFPSM_START,
    DFPSM_RUN
  } dfpsm_state_t;

  // Whole state of the top module
  typedef struct packed {
    dfpsm_state_t state;       // Sequencer state
    logic [31:0]  startTimer;  // Start-up elapsed cycles
    logic [31:0]  stepTimer;   // Cycles inside one duty step
    logic [7:0]   stepCnt;     // Duty step inside the period
    logic [8:0]   activeDuty;  // Duty in steps for this period
    logic         pwm;         // Drive output
    logic [3:0]   dutyCode;    // Duty register
    logic [31:0]  gateTimer;   // Speed gate window cycles
    logic         gateEnd;     // Gate window end pulse
    logic [8:0]   read1;       // Fan 1 reading as presented
    logic [8:0]   read2;       // Fan 2 reading as presented
    logic         otFlag;      // Over-temperature status bit
    logic         otAlarmN;    // Over-temperature alarm, active low
  } dfpsm_top_state_t;

  // Whole state of one fan meter
  typedef struct packed {
    logic        sync1;        // Synchroniser first stage
    logic        sync2;        // Synchroniser second stage
    logic        prev;         // Previous synchronised level
    logic [15:0] pulseCnt;     // Pulses in the running window
    logic [8:0]  count;        // Last speed count
    logic        ovf;          // Speed overflow flag
  } dfpsm_meter_state_t;

endpackage : dfpsm_pkg

//--- hw/dfpsm_top.sv
// Dual fan PWM drive with duty source selection, start-up, shutdown and speed readings
//
// Behaviour
// (R1) Duty source follows config bit 5, analog default
// (R2) Open analog input gives duty code 0010
// (R3) Source switch takes effect without reset or shutdown
// (R4) Analog 1.62 V to 2.6 V maps 30%-100%
// (R5) Analog below range clamps duty at 30%
// (R6) Analog above range raises alarm and status bit
// (R7) Host sets source bit, then writes duty code
// (R8) Four-bit duty register, 30% plus 4.67 per code
// (R9) Power-up and shutdown exit force 100% duty
// (R10) Full-on one second, then source is chosen
// (R11) Only the shutdown bit stops the drive
// (R12) Stalled fan still gets programmed duty pulses
// (R13) Pulses per rev 1/2/4/8 per fan field
// (R14) Nine-bit read-only speed, 25 RPM per count
// (R15) Fine bit picks 25 RPM, else 50 RPM
// (R16) Speed above 12775 RPM sets overflow flag
// (R17) Overflow clears after 2.4 s below maximum
// (R18) Duty changes land on PWM period boundary
// (R19) Sense inputs synchronised, each edge counted once
`timescale 1ns/1ps
`default_nettype none
`include "dfpsm_params.svh"

module dfpsm_top
  import dfpsm_pkg::*;
#(
  parameter logic [31:0] STARTUP_CYCLES = `DFPSM_STARTUP_CYCLES,  // Full-on start-up length
  parameter logic [31:0] GATE_CYCLES    = `DFPSM_GATE_CYCLES,     // Speed gate window length
  parameter logic [31:0] STEP_CYCLES    = `DFPSM_PWM_STEP_CYCLES  // Cycles per duty step
) (
  input  wire logic        sys_clk,             // System clock, 100 MHz
  input  wire logic        rstn,                // Synchronous reset, active low
  input  wire logic        shutdownRequest,     // Config bit 0
  input  wire logic [1:0]  fan1PulsesPerRev,    // Config bits 2-1
  input  wire logic [1:0]  fan2PulsesPerRev,    // Config bits 4-3
  input  wire logic        dutySourceSelect,    // Config bit 5, 1 selects register
  input  wire logic        speedFineResolution, // Config bit 6
  input  wire logic        dutyWrEn,            // Duty register write strobe
  input  wire logic [3:0]  dutyWrData,          // Duty register write data
  input  wire logic [11:0] analogTempInput,     // Analog input in millivolts
  input  wire logic        analogInputOpen,     // Analog input unconnected
  input  wire logic        fan1PulseIn,         // Fan 1 commutation sense
  input  wire logic        fan2PulseIn,         // Fan 2 commutation sense
  output var  logic        pwmDriveOut,         // Fan drive, active high
  output var  logic [3:0]  pwmDutyCode,         // Duty register read back
  output var  logic [8:0]  fan1SpeedReading,    // Fan 1 speed register
  output var  logic [8:0]  fan2SpeedReading,    // Fan 2 speed register
  output var  logic        fan1SpeedOverflow,   // Status bit 3
  output var  logic        fan2SpeedOverflow,   // Status bit 4
  output var  logic        overtempFlag,        // Status bit 5
  output var  logic        overtempAlarmN       // Over-temperature alarm, active low
);

  ////////////////////////////////////////////////////////////////////////////
  // State and reset value

  dfpsm_top_state_t cur;  // Registered state
  dfpsm_top_state_t nxt;  // Next state

  // Reset is a power-up: start in the forced full-on phase
  localparam dfpsm_top_state_t TOP_RESET = '{
    state:      DFPSM_START,
    startTimer: 32'h0000_0000,
    stepTimer:  32'h0000_0000,
    stepCnt:    8'h00,
    activeDuty: `DFPSM_DUTY_FULL_STEPS,
    pwm:        1'b0,
    dutyCode:   `DFPSM_DUTY_RESET,
    gateTimer:  32'h0000_0000,
    gateEnd:    1'b0,
    read1:      9'h000,
    read2:      9'h000,
    otFlag:     1'b0,
    otAlarmN:   1'b1
  };

  ////////////////////////////////////////////////////////////////////////////
  // Fan meters

  logic [1:0]       fanPulse;   // Sense inputs by fan
  logic [1:0][1:0]  fanPpr;     // Pulses per rev codes by fan
  logic [1:0][8:0]  fanCount;   // Raw speed counts by fan
  logic [1:0]       fanOvf;     // Overflow flags by fan

  assign fanPulse  = {fan2PulseIn, fan1PulseIn};
  assign fanPpr[0] = fan1PulsesPerRev;
  assign fanPpr[1] = fan2PulsesPerRev;

  // One meter per fan, sharing the gate window
  for (genvar g = 0; g < 2; g++) begin : gFan
    dfpsm_fan_meter u_dfpsm_fan_meter (
      .sys_clk    (sys_clk),
      .rstn       (rstn),
      .pulseIn    (fanPulse[g]),
      .pprCode    (fanPpr[g]),
      .gateEnd    (cur.gateEnd),
      .speedCount (fanCount[g]),
      .overflow   (fanOvf[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty conversion

  // Duty code to steps of 256: 30 % plus 14/300 per code
  function automatic logic [8:0] codeSteps(input logic [3:0] code);
    logic [31:0] parts;
    logic [31:0] steps;
    parts = `DFPSM_DUTY_BASE_PARTS + (`DFPSM_DUTY_CODE_PARTS * {28'h0, code});
    // Truncation keeps every code within one step of its table value
    steps = (parts * `DFPSM_PWM_STEPS) / `DFPSM_DUTY_ALL_PARTS;
    return steps[8:0];
  endfunction : codeSteps

  // Analog millivolts to steps of 256, clamped at both ends
  function automatic logic [8:0] analogSteps(input logic [11:0] mv);
    logic [31:0] delta;
    logic [31:0] steps;
    delta = 32'h0;
    steps = 32'h0;
    if (mv <= `DFPSM_VIN_LOW_MV) begin
      // Below the range the floor holds
      steps = {23'h0, `DFPSM_DUTY_MIN_STEPS};  // R5
    end else if (mv >= `DFPSM_VIN_HIGH_MV) begin
      steps = {23'h0, `DFPSM_DUTY_FULL_STEPS};  // R4
    end else begin
      // Straight line between 30 % and 100 %
      delta = {20'h0, mv - `DFPSM_VIN_LOW_MV};
      steps = {23'h0, `DFPSM_DUTY_MIN_STEPS}
            + (delta * `DFPSM_DUTY_RISE_STEPS) / `DFPSM_VIN_SPAN_MV;  // R4
    end
    return steps[8:0];
  endfunction : analogSteps

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [8:0] targetDuty;  // Duty the selected source asks for
  logic       stepDone;    // Last cycle of a duty step
  logic       periodWrap;  // Last cycle of a PWM period
  logic       overTemp;    // Analog input above its range

  // Source select, sequencer, PWM counter, gate timer and status
  always_comb begin
    nxt        = cur;
    targetDuty = `DFPSM_DUTY_FULL_STEPS;
    stepDone   = 1'b0;
    periodWrap = 1'b0;
    overTemp   = 1'b0;

    // Duty register write; it is always writable
    if (dutyWrEn) begin
      nxt.dutyCode = dutyWrData;  // R8
    end

    // Source is read live, so a switch needs no reset; host writes code after select
    if (dutySourceSelect) begin
      targetDuty = codeSteps(cur.dutyCode);  // R1 R3 R7 R8
    end else if (analogInputOpen) begin
      targetDuty = codeSteps(`DFPSM_DUTY_OPEN_CODE);  // R2
    end else begin
      targetDuty = analogSteps(analogTempInput);  // R1 R4 R5
    end

    // PWM period counter: steps of STEP_CYCLES, 256 steps a period
    stepDone   = (cur.stepTimer == STEP_CYCLES - 32'h1);
    periodWrap = stepDone && (cur.stepCnt == `DFPSM_PWM_LAST_STEP);
    if (stepDone) begin
      nxt.stepTimer = 32'h0;
      nxt.stepCnt   = cur.stepCnt + 8'h01;
    end else begin
      nxt.stepTimer = cur.stepTimer + 32'h1;
    end

    // Drive sequencer
    case (cur.state)
      DFPSM_SHUT: begin
        // Leaving shutdown restarts a fresh period at full on
        if (!shutdownRequest) begin
          nxt.state      = DFPSM_START;  // R9
          nxt.startTimer = 32'h0;
          nxt.stepTimer  = 32'h0;
          nxt.stepCnt    = 8'h00;
          nxt.activeDuty = `DFPSM_DUTY_FULL_STEPS;  // R9
        end
      end
      DFPSM_START: begin
        // Full on throughout; the source is not looked at yet
        nxt.activeDuty = `DFPSM_DUTY_FULL_STEPS;  // R9 R10
        if (cur.startTimer == STARTUP_CYCLES - 32'h1) begin
          nxt.state = DFPSM_RUN;  // R10
        end else begin
          nxt.startTimer = cur.startTimer + 32'h1;
        end
      end
      DFPSM_RUN: begin
        // New duty only at a period boundary, so no pulse is cut short
        if (periodWrap) begin
          nxt.activeDuty = targetDuty;  // R18
        end
      end
      default: begin
        nxt.state = DFPSM_START;
      end
    endcase

    // Shutdown wins from any state; nothing else stops the drive
    if (shutdownRequest) begin
      nxt.state = DFPSM_SHUT;  // R11
    end

    // High while the step is below the duty; a fan fault never gates this
    nxt.pwm = (nxt.state != DFPSM_SHUT)
           && ({1'b0, nxt.stepCnt} < nxt.activeDuty);  // R11 R12

    // Speed gate window, free running
    nxt.gateEnd = 1'b0;
    if (cur.gateTimer == GATE_CYCLES - 32'h1) begin
      nxt.gateTimer = 32'h0;
      nxt.gateEnd   = 1'b1;
    end else begin
      nxt.gateTimer = cur.gateTimer + 32'h1;
    end

    // Fine resolution shows all nine bits, coarse drops the lowest
    if (speedFineResolution) begin
      nxt.read1 = fanCount[0];  // R15
      nxt.read2 = fanCount[1];  // R15
    end else begin
      nxt.read1 = {1'b0, fanCount[0][8:1]};  // R15
      nxt.read2 = {1'b0, fanCount[1][8:1]};  // R15
    end

    // Over-temperature follows the input level, clearing when it falls back
    overTemp     = !analogInputOpen && (analogTempInput > `DFPSM_VIN_HIGH_MV);
    nxt.otFlag   = overTemp;  // R6
    nxt.otAlarmN = ~overTemp;  // R6
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Single state register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cur <= TOP_RESET;
    end else begin
      cur <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  assign pwmDriveOut       = cur.pwm;
  assign pwmDutyCode       = cur.dutyCode;
  assign fan1SpeedReading  = cur.read1;
  assign fan2SpeedReading  = cur.read2;
  assign fan1SpeedOverflow = fanOvf[0];
  assign fan2SpeedOverflow = fanOvf[1];
  assign overtempFlag      = cur.otFlag;
  assign overtempAlarmN    = cur.otAlarmN;

endmodule : dfpsm_top
`default_nettype wire

//--- testbench/dfpsm_bench.sv
// Self-checking bench for the dual fan PWM drive and speed monitor
`timescale 1ns/1ps
`default_nettype none
module dfpsm_bench
  import dfpsm_pkg::*;
;
  localparam logic [31:0] START = 32'h32;  // Shortened start-up
  localparam logic [31:0] GATE  = 32'h7d0; // Shortened gate window
  localparam logic [31:0] STEP  = 32'h4;   // Period of 1024 cycles
  localparam int          PER   = 1024;    // PWM period in cycles
  logic        sys_clk = 1'b0, rstn = 1'b0, shutdownRequest = 1'b0;
  logic [1:0]  fan1PulsesPerRev = 2'h1, fan2PulsesPerRev = 2'h1;
  logic        dutySourceSelect = 1'b0, speedFineResolution = 1'b0;
  logic        dutyWrEn = 1'b0, analogInputOpen = 1'b0;
  logic [3:0]  dutyWrData = 4'h0;
  logic [11:0] analogTempInput = 12'h000;
  logic [15:0] gap1 = 16'h0000, gap2 = 16'h0000; // Fan pulse spacing
  logic        fan1PulseIn, fan2PulseIn, pwmDriveOut, fan1SpeedOverflow, fan2SpeedOverflow;
  logic        overtempFlag, overtempAlarmN;
  logic [3:0]  pwmDutyCode;
  logic [8:0]  fan1SpeedReading, fan2SpeedReading;
  int          badCount = 0, comparisons = 0, seed = 84961;
  always #5 sys_clk = ~sys_clk;
  dfpsm_top #(.STARTUP_CYCLES(START), .GATE_CYCLES(GATE), .STEP_CYCLES(STEP)) u_dfpsm_top (
    .sys_clk(sys_clk), .rstn(rstn), .shutdownRequest(shutdownRequest),
    .fan1PulsesPerRev(fan1PulsesPerRev), .fan2PulsesPerRev(fan2PulsesPerRev),
    .dutySourceSelect(dutySourceSelect), .speedFineResolution(speedFineResolution),
    .dutyWrEn(dutyWrEn), .dutyWrData(dutyWrData), .analogTempInput(analogTempInput),
    .analogInputOpen(analogInputOpen), .fan1PulseIn(fan1PulseIn), .fan2PulseIn(fan2PulseIn),
    .pwmDriveOut(pwmDriveOut), .pwmDutyCode(pwmDutyCode), .fan1SpeedReading(fan1SpeedReading),
    .fan2SpeedReading(fan2SpeedReading), .fan1SpeedOverflow(fan1SpeedOverflow),
    .fan2SpeedOverflow(fan2SpeedOverflow), .overtempFlag(overtempFlag), .overtempAlarmN(overtempAlarmN));
  dfpsm_fan_model u_fan1 (.sys_clk(sys_clk), .pulseGap(gap1), .pulseOut(fan1PulseIn));
  dfpsm_fan_model u_fan2 (.sys_clk(sys_clk), .pulseGap(gap2), .pulseOut(fan2PulseIn));
  //////////////////////////////////////////////////////////////////////
  // Compare within a tolerance; unknowns never match
  task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got, input int tol);
    int diff;
    diff = int'(got) - int'(expv);
    comparisons++;
    if (got !== expv && (^got === 1'bx || diff > tol || diff < -tol)) begin
      badCount++;
      $display("[ERR] %s expected %0d seen %0d", what, expv, got);
    end
  endtask : chk
  // Counts, verdict and end of run
  task automatic endOfTest();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : endOfTest
  // Expected duty steps for a register code, truncated to 256 steps
  function automatic int codeSteps(input int code);
    return (256 * (90 + 14 * code)) / 300;
  endfunction : codeSteps
  // Expected duty steps for an analog level, clamped at both ends
  function automatic int analogSteps(input int mv);
    if (mv <= 1620) return 77;
    if (mv >= 2600) return 256;
    return 77 + ((mv - 1620) * 179) / 980;
  endfunction : analogSteps
  // Two periods let a change reach a period boundary, then one period is counted
  task automatic dutyCheck(input string what, input int steps);
    int hi;
    hi = 0;
    repeat (2 * PER) @(posedge sys_clk);
    repeat (PER) begin
      @(posedge sys_clk);
      #1;
      if (pwmDriveOut === 1'b1) hi++;
    end
    chk(what, 16'(steps * 4), 16'(hi), 0);
  endtask : dutyCheck
  // One-cycle write strobe, readback after the taking edge
  task automatic writeDuty(input logic [3:0] code);
    @(posedge sys_clk);
    dutyWrEn <= 1'b1;
    dutyWrData <= code;
    @(posedge sys_clk);
    dutyWrEn <= 1'b0;
    #1;
    chk("duty readback", 16'(code), 16'(pwmDutyCode), 0);
  endtask : writeDuty
  //////////////////////////////////////////////////////////////////////
  initial begin
    int k, n, p1, p2, code, e1, e2;
    int mvTab[$];
    mvTab = '{1000, 1620, 2100, 2599, 2700, 2700};
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    gap1 <= 16'(20 + ($random(seed) & 63));
    gap2 <= 16'(20 + ($random(seed) & 63));
    @(posedge sys_clk);
    #1;
    chk("duty reset", 16'h0002, 16'(pwmDutyCode), 0);
    // Analog levels below, inside and above range, then an open pin
    foreach (mvTab[i]) begin
      @(posedge sys_clk);
      analogTempInput <= 12'(mvTab[i]);
      analogInputOpen <= (i == 5);
      dutyCheck("analog duty", i == 5 ? codeSteps(2) : analogSteps(mvTab[i]));
      chk("overtemp flag", 16'(i < 5 && mvTab[i] > 2600), 16'(overtempFlag), 0);
      chk("overtemp alarm", 16'(!(i < 5 && mvTab[i] > 2600)), 16'(overtempAlarmN), 0);
    end
    // Register control with both rotors locked
    @(posedge sys_clk);
    gap1 <= 16'h0000;
    gap2 <= 16'h0000;
    dutySourceSelect <= 1'b1;
    for (k = 0; k < 4; k++) begin
      code = (k == 0) ? 0 : (k == 1) ? 15 : ($random(seed) & 15);
      writeDuty(4'(code));
      dutyCheck("register duty", codeSteps(code));
    end
    // Back to analog control live, no reset in between
    @(posedge sys_clk);
    dutySourceSelect <= 1'b0;
    analogInputOpen <= 1'b0;
    analogTempInput <= 12'h834;
    dutyCheck("source switch", analogSteps(2100));
    @(posedge sys_clk);
    shutdownRequest <= 1'b1;
    dutyCheck("shutdown duty", 0);
    chk("duty kept", 16'(code), 16'(pwmDutyCode), 0);
    @(posedge sys_clk);
    shutdownRequest <= 1'b0;
    dutyCheck("restart duty", analogSteps(2100));
    // Every pulses-per-rev code, both resolutions, one overflowing fan
    for (k = 0; k < 4; k++) begin
      p1 = (k == 0) ? 3 : 20 + ($random(seed) & 63);
      p2 = 20 + ($random(seed) & 63);
      @(posedge sys_clk);
      gap1 <= 16'(p1);
      gap2 <= 16'(p2);
      fan1PulsesPerRev <= 2'(k);
      fan2PulsesPerRev <= 2'(3 - k);
      speedFineResolution <= k[0];
      for (n = 0; k == 0 && n < 3 * GATE && fan1SpeedOverflow !== 1'b1; n++) begin
        @(posedge sys_clk);
        #1;
      end
      if (n >= 3 * GATE) begin
        badCount++;
        $display("[ERR] overflow wait expected 1 seen 0");
        endOfTest();
      end
      repeat (2 * GATE + 5) @(posedge sys_clk);
      #1;
      e1 = (GATE / p1) >> k;
      e2 = (GATE / p2) >> (3 - k);
      chk("fan1 overflow", 16'(e1 > 511), 16'(fan1SpeedOverflow), 0);
      chk("fan2 overflow", 16'(e2 > 511), 16'(fan2SpeedOverflow), 0);
      chk("fan1 reading", 16'((e1 > 511 ? 511 : e1) >> !k[0]), 16'(fan1SpeedReading), 1);
      chk("fan2 reading", 16'((e2 > 511 ? 511 : e2) >> !k[0]), 16'(fan2SpeedReading), 1);
    end
    endOfTest();
  end
endmodule : dfpsm_bench
bind dfpsm_top dfpsm_checker #(.STARTUP_CYCLES(STARTUP_CYCLES), .GATE_CYCLES(GATE_CYCLES),
  .STEP_CYCLES(STEP_CYCLES)) u_dfpsm_checker (
  .sys_clk(sys_clk), .rstn(rstn), .shutdownRequest(shutdownRequest), .speedFineResolution(speedFineResolution),
  .dutyWrEn(dutyWrEn), .dutyWrData(dutyWrData), .analogTempInput(analogTempInput),
  .analogInputOpen(analogInputOpen), .pwmDriveOut(pwmDriveOut), .pwmDutyCode(pwmDutyCode),
  .fan1SpeedReading(fan1SpeedReading), .fan1SpeedOverflow(fan1SpeedOverflow),
  .overtempFlag(overtempFlag), .overtempAlarmN(overtempAlarmN));
`default_nettype wire

//--- testbench/dfpsm_checker.sv
// Port checker for the dual fan PWM drive and speed monitor
`timescale 1ns/1ps
`default_nettype none
module dfpsm_checker #(
  parameter logic [31:0] STARTUP_CYCLES = 32'h32,  // Full-on start-up cycles
  parameter logic [31:0] GATE_CYCLES    = 32'h7d0, // Speed gate window cycles
  parameter logic [31:0] STEP_CYCLES    = 32'h4    // Cycles per duty step
) (
  input wire logic        sys_clk,             // System clock
  input wire logic        rstn,                // Reset, active low
  input wire logic        shutdownRequest,     // Shutdown bit
  input wire logic        speedFineResolution, // Fine reading bit
  input wire logic        dutyWrEn,            // Duty write strobe
  input wire logic [3:0]  dutyWrData,          // Duty write data
  input wire logic [11:0] analogTempInput,     // Analog level, mV
  input wire logic        analogInputOpen,     // Analog pin open
  input wire logic        pwmDriveOut,         // Fan drive
  input wire logic [3:0]  pwmDutyCode,         // Duty readback
  input wire logic [8:0]  fan1SpeedReading,    // Fan 1 reading
  input wire logic        fan1SpeedOverflow,   // Fan 1 overflow
  input wire logic        overtempFlag,        // Overtemp status
  input wire logic        overtempAlarmN       // Overtemp alarm
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////
  logic [31:0] startCnt_r; // Cycles since reset or shutdown exit
  logic [31:0] ovfGap_r;   // Cycles since fan 1 overflow last moved
  logic [31:0] hiCnt_r;    // Cycles the drive has stood high
  // Saturating counters; long spans cannot be written as repetitions
  always_ff @(posedge sys_clk) begin
    if (!rstn || shutdownRequest) begin
      startCnt_r <= 32'h0;
    end else if (startCnt_r != 32'hffffffff) begin
      startCnt_r <= startCnt_r + 32'h1;
    end
    if (!rstn || $changed(fan1SpeedOverflow)) begin
      ovfGap_r <= 32'h0;
    end else if (ovfGap_r != 32'hffffffff) begin
      ovfGap_r <= ovfGap_r + 32'h1;
    end
    if (!rstn || !pwmDriveOut) begin
      hiCnt_r <= 32'h0;
    end else if (hiCnt_r != 32'hffffffff) begin
      hiCnt_r <= hiCnt_r + 32'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  AST_RESET_VALUES: assert property (disable iff (1'b0)
    !rstn |=> pwmDutyCode == 4'h2 && !pwmDriveOut && overtempAlarmN && fan1SpeedReading == 9'h000)
    else $error("reset values wrong");
  AST_DUTY_WRITE: assert property (
    dutyWrEn |=> pwmDutyCode == $past(dutyWrData)) else $error("duty write not taken");
  AST_DUTY_HOLD: assert property (
    !dutyWrEn |=> $stable(pwmDutyCode)) else $error("duty code moved without a write");
  AST_SHUTDOWN_OFF: assert property (
    shutdownRequest |=> !pwmDriveOut) else $error("drive active in shutdown");
  AST_STARTUP_FULL: assert property (
    startCnt_r != 32'h0 && startCnt_r <= STARTUP_CYCLES && !shutdownRequest |-> pwmDriveOut)
    else $error("drive not full on during start-up");
  AST_OT_FLAG: assert property (
    1'b1 |=> overtempFlag == $past(!analogInputOpen && analogTempInput > 12'ha28))
    else $error("overtemp flag wrong");
  AST_OT_ALARM: assert property (
    $rose(overtempFlag) |-> $fell(overtempAlarmN)) else $error("alarm did not follow flag");
  AST_OVF_READING: assert property (
    $rose(fan1SpeedOverflow) |=> fan1SpeedReading == (speedFineResolution ? 9'h1ff : 9'h0ff))
    else $error("saturated reading wrong");
  AST_OVF_SPACING: assert property (
    $changed(fan1SpeedOverflow) |-> ovfGap_r >= GATE_CYCLES - 32'h2)
    else $error("overflow moved inside a window");
  // A pulse cut at a mid-period duty change would fall below the 30 % floor
  AST_PULSE_WHOLE: assert property (
    $fell(pwmDriveOut) && !$past(shutdownRequest) |-> hiCnt_r >= 32'h4c * STEP_CYCLES)
    else $error("drive pulse cut short");
  COV_OVF: cover property ($rose(fan1SpeedOverflow));
  COV_SHUT_EXIT: cover property ($fell(shutdownRequest));
  COV_OT: cover property ($rose(overtempFlag));
endmodule : dfpsm_checker
`default_nettype wire

//--- testbench/dfpsm_fan_model.sv
// Fan commutation pulse source standing in for a fan on a sense input
`timescale 1ns/1ps
`default_nettype none
module dfpsm_fan_model (
  input  wire logic        sys_clk,  // System clock
  input  wire logic [15:0] pulseGap, // Cycles per pulse, zero when stalled
  output var  logic        pulseOut  // Sense pulse, one cycle high
);
  logic [15:0] tick_r; // Cycle within the pulse period
  // Free-running phase, so pulses fall anywhere in the gate window
  always_ff @(posedge sys_clk) begin
    if (pulseGap == 16'h0000 || tick_r >= pulseGap - 16'h0001) begin
      tick_r <= 16'h0000;
    end else begin
      tick_r <= tick_r + 16'h0001;
    end
  end
  // A locked rotor draws no pulses, so the coupled line rests low
  assign pulseOut = pulseGap != 16'h0000 && tick_r == 16'h0000;
endmodule : dfpsm_fan_model
`default_nettype wire
